// ---- rtl/tmc_timer_ctrl.v ----
// 16-bit timer with waveform mode decode, input capture and clock select
//
// Design decision made here: the address-and-strobe port.
`include "tmc_defs.vh"

module tmc_timer_ctrl (
  input  wire       clock,        // I/O clock, 40 MHz
  input  wire       arst_n,       // Async reset, active low
  input  wire [7:0] reg_addr,     // Register address
  input  wire [7:0] reg_wdata,    // Write data
  input  wire       reg_wr,       // Write strobe
  input  wire       reg_rd,       // Read strobe
  output reg  [7:0] reg_rdata,    // Read data, cycle after strobe
  input  wire       capture_input_pin,  // Capture pin, asynchronous
  input  wire       external_count_pin, // External count pin, asynchronous
  output reg  [15:0] count_out,   // Counter value
  output reg  [15:0] cmp_a_active, // Active compare A value
  output reg        count_down,   // Counting direction
  output reg        irq           // Interrupt, level
);

  // ****************************************
  // Registers
  // ****************************************
  reg  [7:0]  timer_control_a_r;
  reg  [7:0]  timer_control_b_r;
  reg  [15:0] capture_value_reg_r;
  reg  [15:0] compare_a_reg_r;
  reg  [1:0]  irq_stat_r;
  reg  [1:0]  irq_mask_r;
  reg  [9:0]  presc_r;
  reg  [1:0]  cap_sync_r;
  reg  [1:0]  ext_sync_r;
  reg         ext_prev_r;
  reg         cap_prev_r;

  wire [3:0] waveform_mode = {timer_control_b_r[`TMC_B_WGM_HI:`TMC_B_WGM_LO],
                              timer_control_a_r[1:0]}; // RULE1
  wire [2:0] clock_select_field      = timer_control_b_r[2:0];
  wire       capture_edge_sel        = timer_control_b_r[`TMC_B_EDGE];
  wire       capture_noise_filter_en = timer_control_b_r[`TMC_B_NOISE];
  wire       cap_filt;

  // ****************************************
  // Mode decode
  // ****************************************
  localparam UPD_IMM = 2'd0;
  localparam UPD_TOP = 2'd1;
  localparam UPD_BOT = 2'd2;
  localparam OVF_MAX = 2'd0;
  localparam OVF_TOP = 2'd1;
  localparam OVF_BOT = 2'd2;

  function [15:0] top_of;
    input [3:0]  m;
    input [15:0] capv;
    input [15:0] cmpa;
    begin
      case (m)
        4'h0:    top_of = `TMC_MAX;                    // RULE17
        4'h1:    top_of = `TMC_TOP_8;                  // RULE17
        4'h2:    top_of = `TMC_TOP_9;                  // RULE2
        4'h3:    top_of = `TMC_TOP_10;                 // RULE2
        4'h4:    top_of = cmpa;                        // RULE3
        4'h5:    top_of = `TMC_TOP_8;                  // RULE4
        4'h6:    top_of = `TMC_TOP_9;                  // RULE4
        4'h7:    top_of = `TMC_TOP_10;                 // RULE4
        4'h8:    top_of = capv;                        // RULE5
        4'h9:    top_of = cmpa;                        // RULE5
        4'hA:    top_of = capv;                        // RULE6
        4'hB:    top_of = cmpa;                        // RULE6
        4'hC:    top_of = capv;                        // RULE7
        4'hE:    top_of = capv;                        // RULE9
        4'hF:    top_of = cmpa;                        // RULE9
        default: top_of = `TMC_MAX;                    // RULE8
      endcase
    end
  endfunction

  function [1:0] upd_of;
    input [3:0] m;
    begin
      case (m)
        4'h0, 4'h4, 4'hC:        upd_of = UPD_IMM;  // RULE3 RULE7 RULE17
        4'h1, 4'h2, 4'h3:        upd_of = UPD_TOP;  // RULE2
        4'hA, 4'hB:              upd_of = UPD_TOP;  // RULE6
        default:                 upd_of = UPD_BOT;  // RULE4 RULE5 RULE9
      endcase
    end
  endfunction

  function [1:0] ovf_of;
    input [3:0] m;
    begin
      case (m)
        4'h0, 4'h4, 4'hC, 4'hD:  ovf_of = OVF_MAX;  // RULE3 RULE7
        4'h5, 4'h6, 4'h7:        ovf_of = OVF_TOP;  // RULE4
        4'hE, 4'hF:              ovf_of = OVF_TOP;  // RULE9
        default:                 ovf_of = OVF_BOT;  // RULE2 RULE5 RULE6
      endcase
    end
  endfunction

  // Write strobe aimed at one byte address
  function wr_at;
    input       wr;
    input [7:0] addr;
    input [7:0] target;
    begin
      wr_at = wr && (addr == target);
    end
  endfunction

  // Buffered compare A as TOP, so buffered modes move TOP only at their update point
  wire [15:0] top_val   = top_of(waveform_mode, capture_value_reg_r, cmp_a_active);
  wire [1:0]  upd_pt    = upd_of(waveform_mode);
  wire [1:0]  ovf_pt    = ovf_of(waveform_mode);
  wire        dual      = (waveform_mode == 4'h1) || (waveform_mode == 4'h2) ||
                          (waveform_mode == 4'h3) || (waveform_mode[3:2] == 2'b10);
  wire        cap_is_top = (waveform_mode == 4'h8) || (waveform_mode == 4'hA) ||
                           (waveform_mode == 4'hC) || (waveform_mode == 4'hE);

  // ****************************************
  // Pin synchronisers and filter
  // ****************************************
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cap_sync_r <= 2'b11;
      ext_sync_r <= 2'b00;
    end else begin
      cap_sync_r <= {cap_sync_r[0], capture_input_pin};
      ext_sync_r <= {ext_sync_r[0], external_count_pin};
    end
  end

  tmc_capture_filter #(
    .LEN       (`TMC_FILTER_LEN)
  ) u_filter (
    .clock     (clock),
    .arst_n    (arst_n),
    .sample    (cap_sync_r[1]),
    .enable    (capture_noise_filter_en),
    .level_out (cap_filt)
  );

  // ****************************************
  // Clock select and prescaler
  // ****************************************
  // Each tap fires on the last cycle of its period; all taps share one counter
  localparam [39:0] TAP_MASK = {`TMC_DIV_1024, `TMC_DIV_256, `TMC_DIV_64, `TMC_DIV_8};
  wire [3:0] tap_hit;
  genvar     gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_tap
      assign tap_hit[gi] = ((presc_r & TAP_MASK[gi*10 +: 10]) == TAP_MASK[gi*10 +: 10]);
    end
  endgenerate

  reg tick;
  always @* begin
    case (clock_select_field)
      3'b000:  tick = 1'b0;                                 // RULE14
      3'b001:  tick = 1'b1;                                 // RULE15
      3'b010:  tick = tap_hit[0];                           // RULE15
      3'b011:  tick = tap_hit[1];                           // RULE15
      3'b100:  tick = tap_hit[2];                           // RULE15
      3'b101:  tick = tap_hit[3];                           // RULE15
      3'b110:  tick = ext_prev_r & ~ext_sync_r[1];          // RULE16
      default: tick = ~ext_prev_r & ext_sync_r[1];          // RULE16
    endcase
  end

  // Free-running prescaler, shared by all divide taps
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      presc_r    <= 10'h000;
      ext_prev_r <= 1'b0;
    end else begin
      presc_r    <= presc_r + 10'h001;
      ext_prev_r <= ext_sync_r[1];
    end
  end

  // ****************************************
  // Capture edge detection
  // ****************************************
  wire cap_rise = ~cap_prev_r & cap_filt;
  wire cap_fall = cap_prev_r & ~cap_filt;
  wire cap_evt  = ~cap_is_top & (capture_edge_sel ? cap_rise : cap_fall); // RULE11 RULE13

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cap_prev_r <= 1'b1;
    end else begin
      cap_prev_r <= cap_filt;
    end
  end

  // ****************************************
  // Counter
  // ****************************************
  reg  [15:0] cnt_nxt;
  reg         dir_nxt;
  reg         ovf_evt;
  reg         load_evt;
  wire        at_top = (count_out >= top_val);
  wire        at_bot = (count_out == `TMC_BOTTOM);

  always @* begin
    cnt_nxt  = count_out;
    dir_nxt  = count_down;
    ovf_evt  = 1'b0;
    load_evt = 1'b0;
    if (tick) begin
      if (dual) begin
        // Phase correct and phase-frequency correct: turn round at TOP and at BOTTOM
        if (!count_down) begin
          if (at_top) begin
            dir_nxt = 1'b1;
            cnt_nxt = count_out - 16'h0001;
            load_evt = (upd_pt == UPD_TOP);                // RULE2 RULE6
          end else begin
            cnt_nxt = count_out + 16'h0001;
          end
        end else begin
          if (at_bot) begin
            dir_nxt = 1'b0;
            cnt_nxt = count_out + 16'h0001;
          end else begin
            cnt_nxt = count_out - 16'h0001;
            if (count_out == 16'h0001) begin
              ovf_evt  = (ovf_pt == OVF_BOT);               // RULE2 RULE5 RULE6
              load_evt = (upd_pt == UPD_BOT);               // RULE5
            end
          end
        end
      end else begin
        dir_nxt = 1'b0;
        if (at_top) begin
          cnt_nxt  = `TMC_BOTTOM;
          load_evt = (upd_pt == UPD_BOT);                   // RULE4 RULE9
          ovf_evt  = (ovf_pt == OVF_TOP) ||
                     ((ovf_pt == OVF_MAX) && (count_out == `TMC_MAX)); // RULE3 RULE7
        end else begin
          cnt_nxt = count_out + 16'h0001;
        end
      end
    end
  end

  // Software write to the counter overrides counting in that cycle
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      count_out  <= 16'h0000;
      count_down <= 1'b0;
    end else begin
      if (wr_at(reg_wr, reg_addr, `TMC_OFS_COUNT_L)) begin
        count_out <= {count_out[15:8], reg_wdata};
      end else if (wr_at(reg_wr, reg_addr, `TMC_OFS_COUNT_H)) begin
        count_out <= {reg_wdata, count_out[7:0]};
      end else begin
        count_out <= cnt_nxt;
      end
      count_down <= dir_nxt;
    end
  end

  // Compare A buffer
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cmp_a_active <= 16'h0000;
    end else if (upd_pt == UPD_IMM || load_evt) begin
      cmp_a_active <= compare_a_reg_r;                      // RULE3 RULE7 RULE17
    end
  end

  // Capture wins over a software write in the same cycle
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      capture_value_reg_r <= 16'h0000;
    end else if (cap_evt) begin
      capture_value_reg_r <= count_out;                     // RULE12
    end else if (wr_at(reg_wr, reg_addr, `TMC_OFS_CAPT_L)) begin
      capture_value_reg_r <= {capture_value_reg_r[15:8], reg_wdata};
    end else if (wr_at(reg_wr, reg_addr, `TMC_OFS_CAPT_H)) begin
      capture_value_reg_r <= {reg_wdata, capture_value_reg_r[7:0]};
    end
  end

  // ****************************************
  // Register file and interrupts
  // ****************************************
  wire [1:0] irq_set = {cap_evt, ovf_evt};                  // RULE12
  wire [1:0] irq_clr = wr_at(reg_wr, reg_addr, `TMC_OFS_IRQ_STAT) ? reg_wdata[1:0] : 2'b00;
  wire [1:0] stat_nxt = (irq_stat_r & ~irq_clr) | irq_set;  // Set wins over clear

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat_r <= 2'b00;
      irq        <= 1'b0;
    end else begin
      irq_stat_r <= stat_nxt;
      irq        <= |(stat_nxt & irq_mask_r);
    end
  end

  // ****************************************
  // Register file
  // ****************************************
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      timer_control_a_r <= `TMC_CTRL_RESET;
      timer_control_b_r <= `TMC_CTRL_RESET;
      compare_a_reg_r   <= 16'h0000;
      irq_mask_r        <= 2'b00;
      reg_rdata         <= 8'h00;
    end else begin
      if (reg_wr) begin
        case (reg_addr)
          `TMC_OFS_CTRL_A:   timer_control_a_r <= reg_wdata & `TMC_CTRL_A_MASK;
          `TMC_OFS_CTRL_B:   timer_control_b_r <= reg_wdata & `TMC_CTRL_B_MASK; // RULE18
          `TMC_OFS_CMPA_L:   compare_a_reg_r   <= {compare_a_reg_r[15:8], reg_wdata};
          `TMC_OFS_CMPA_H:   compare_a_reg_r   <= {reg_wdata, compare_a_reg_r[7:0]};
          `TMC_OFS_IRQ_MASK: irq_mask_r        <= reg_wdata[1:0];
          default: ;
        endcase
      end
      if (reg_rd) begin
        case (reg_addr)
          `TMC_OFS_CTRL_A:   reg_rdata <= timer_control_a_r;
          `TMC_OFS_CTRL_B:   reg_rdata <= timer_control_b_r;  // RULE18
          `TMC_OFS_COUNT_L:  reg_rdata <= count_out[7:0];
          `TMC_OFS_COUNT_H:  reg_rdata <= count_out[15:8];
          `TMC_OFS_CAPT_L:   reg_rdata <= capture_value_reg_r[7:0];
          `TMC_OFS_CAPT_H:   reg_rdata <= capture_value_reg_r[15:8];
          `TMC_OFS_CMPA_L:   reg_rdata <= compare_a_reg_r[7:0];
          `TMC_OFS_CMPA_H:   reg_rdata <= compare_a_reg_r[15:8];
          `TMC_OFS_IRQ_STAT: reg_rdata <= {6'h00, irq_stat_r};
          `TMC_OFS_IRQ_MASK: reg_rdata <= {6'h00, irq_mask_r};
          default:           reg_rdata <= 8'h00;
        endcase
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

endmodule

// ---- rtl/tmc_defs.vh ----
// Constants for the 16-bit timer mode, capture and clock control block
//
// Notes on behaviour
// RULE1: Waveform mode bits 3:2 sit in control B bits 4:3; bits 1:0 in control A.
// RULE2: Modes 2,3 phase correct, TOP 0x01FF/0x03FF, buffers at TOP, overflow at BOTTOM.
// RULE3: Mode 4 clears on compare A as TOP, immediate update, overflow at MAX.
// RULE4: Modes 5,6,7 fast PWM, TOP 0x00FF/0x01FF/0x03FF, load BOTTOM, overflow TOP.
// RULE5: Modes 8,9 phase-frequency correct, TOP capture or compare A, all at BOTTOM.
// RULE6: Modes 10,11 phase correct, TOP capture or compare A, load TOP, overflow BOTTOM.
// RULE7: Mode 12 clears on compare with capture as TOP, immediate, overflow at MAX.
// RULE8: Software must not select reserved mode 13.
// RULE9: Modes 14,15 fast PWM, TOP capture or compare A, load BOTTOM, overflow TOP.
// RULE10: Noise filter changes output only after four equal consecutive samples.
// RULE11: Capture on falling edge when edge select is zero, rising when one.
// RULE12: Capture copies counter into capture register and sets capture flag.
// RULE13: Modes using capture register as TOP disconnect the capture input.
// RULE14: Clock select 000 stops the counter.
// RULE15: Codes 001 to 101 divide the I/O clock by 1, 8, 64, 256, 1024.
// RULE16: Codes 110 and 111 count falling or rising edges of external pin.
// RULE17: Mode 0 normal TOP 0xFFFF; mode 1 phase correct 8-bit TOP 0x00FF.
// RULE18: Control B bit 5 reads zero and ignores writes.
`ifndef TMC_DEFS_VH
`define TMC_DEFS_VH

// ****************************************
// Register offsets
// ****************************************
`define TMC_OFS_CTRL_A   8'h80
`define TMC_OFS_CTRL_B   8'h81
`define TMC_OFS_COUNT_L  8'h84
`define TMC_OFS_COUNT_H  8'h85
`define TMC_OFS_CAPT_L   8'h86
`define TMC_OFS_CAPT_H   8'h87
`define TMC_OFS_CMPA_L   8'h88
`define TMC_OFS_CMPA_H   8'h89
`define TMC_OFS_IRQ_STAT 8'h8C
`define TMC_OFS_IRQ_MASK 8'h8D

// ****************************************
// Field positions and reset values
// ****************************************
`define TMC_B_NOISE      7
`define TMC_B_EDGE       6
`define TMC_B_WGM_HI     4
`define TMC_B_WGM_LO     3
`define TMC_CTRL_B_MASK  8'hDF
`define TMC_CTRL_A_MASK  8'h03
`define TMC_CTRL_RESET   8'h00
`define TMC_IRQ_OVF      0
`define TMC_IRQ_CAPT     1

// ****************************************
// Counter limits and prescaler counts
// ****************************************
`define TMC_TOP_8        16'h00FF
`define TMC_TOP_9        16'h01FF
`define TMC_TOP_10       16'h03FF
`define TMC_MAX          16'hFFFF
`define TMC_BOTTOM       16'h0000
`define TMC_DIV_8        10'h007
`define TMC_DIV_64       10'h03F
`define TMC_DIV_256      10'h0FF
`define TMC_DIV_1024     10'h3FF
`define TMC_FILTER_LEN   4

`endif

// ---- rtl/tmc_capture_filter.v ----
// Capture pin noise filter
`include "tmc_defs.vh"

module tmc_capture_filter #(
  parameter LEN = `TMC_FILTER_LEN
) (
  input  wire clock,     // I/O clock
  input  wire arst_n,    // Async reset, active low
  input  wire sample,    // Synchronised capture level
  input  wire enable,    // Filter on
  output reg  level_out  // Filtered level
);

  reg [LEN-2:0] hist_r;

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      hist_r    <= {(LEN-1){1'b1}};
      level_out <= 1'b1;
    end else begin
      hist_r <= {hist_r[LEN-3:0], sample};
      if (!enable) begin
        level_out <= sample;
      end else if (&{hist_r, sample}) begin
        level_out <= 1'b1; // RULE10
      end else if (~|{hist_r, sample}) begin
        level_out <= 1'b0; // RULE10
      end
    end
  end

endmodule

// ---- verif/tmc_pin_model.sv ----
// Far-side model: capture pin and external count pin
module tmc_pin_model (
  input  logic clock,              // I/O clock
  output logic capture_input_pin,  // Capture pin level
  output logic external_count_pin  // External count pin level
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    capture_input_pin  = 1'b1;
    external_count_pin = 1'b0;
  end
  task automatic cap_to(input logic lvl);
    @(posedge clock);
    capture_input_pin <= lvl;
  endtask
  // Pulse too short to survive the noise filter
  task automatic cap_glitch(input int len);
    @(posedge clock);
    capture_input_pin <= ~capture_input_pin;
    repeat (len) @(posedge clock);
    capture_input_pin <= ~capture_input_pin;
  endtask
  // Levels held several clocks: the pin is resynchronised inside
  task automatic ext_pulse(input int n, input int half);
    repeat (n) begin
      repeat (half) @(posedge clock);
      external_count_pin <= 1'b1;
      repeat (half) @(posedge clock);
      external_count_pin <= 1'b0;
    end
  endtask
endmodule

// ---- verif/tmc_timer_ctrl_assertions.sv ----
// Checker for the timer control block ports
module tmc_timer_ctrl_assertions (
  input logic        clock,        // I/O clock
  input logic        arst_n,       // Reset, active low
  input logic [7:0]  reg_addr,     // Address
  input logic [7:0]  reg_wdata,    // Write data
  input logic        reg_wr,       // Write strobe
  input logic        reg_rd,       // Read strobe
  input logic [7:0]  reg_rdata,    // Read data
  input logic [15:0] count_out,    // Counter
  input logic [15:0] cmp_a_active, // Active compare A
  input logic        count_down    // Direction
);
  logic [7:0] a_r;
  logic [7:0] b_r;
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      a_r <= 8'h00;
      b_r <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == 8'h80) a_r <= reg_wdata;
      if (reg_addr == 8'h81) b_r <= reg_wdata;
    end
  end
  wire [3:0]  mode = {b_r[4:3], a_r[1:0]};
  wire        cwr  = reg_wr && reg_addr[7:1] == 7'h42;
  wire [15:0] top  = mode[1:0] == 2'h1 ? 16'h00FF : mode[1:0] == 2'h2 ? 16'h01FF : 16'h03FF;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // Full-rate counting with settings held; edges where the mode moves are skipped
  sequence s_run;
    b_r[2:0] == 3'h1 && $past(b_r) == b_r && $past(a_r) == a_r && !cwr;
  endsequence
  sequence s_stop;
    b_r[2:0] == 3'h0 && $past(b_r[2:0]) == 3'h0 && !cwr;
  endsequence
  property p_stop;
    s_stop |=> $stable(count_out);
  endproperty
  property p_step;
    s_run ##0 (mode == 4'h0 && count_out != 16'hFFFF) |=> count_out == $past(count_out) + 16'h0001;
  endproperty
  property p_wrap0;
    s_run ##0 (mode == 4'h0 && count_out == 16'hFFFF) |=> count_out == 16'h0000;
  endproperty
  property p_fast;
    s_run ##0 (mode >= 4'h5 && mode <= 4'h7 && count_out == top) |=> count_out == 16'h0000;
  endproperty
  property p_dual;
    s_run ##0 (mode >= 4'h1 && mode <= 4'h3 && count_out == top)
      |=> count_down && count_out == $past(count_out) - 16'h0001;
  endproperty
  property p_ctc;
    s_run ##0 ((mode == 4'h4 || mode == 4'hF) && count_out == cmp_a_active)
      |=> count_out == 16'h0000;
  endproperty
  property p_rd_b;
    reg_rd && reg_addr == 8'h81 |=> reg_rdata == (b_r & 8'hDF);
  endproperty
  property p_rd_a;
    reg_rd && reg_addr == 8'h80 |=> reg_rdata == (a_r & 8'h03);
  endproperty
  a_stop: assert property (p_stop) else $error("counter moved while stopped");
  a_step: assert property (p_step) else $error("undivided step wrong");
  a_wrap0: assert property (p_wrap0) else $error("normal wrap wrong");
  a_fast: assert property (p_fast) else $error("fast wrap wrong");
  a_dual: assert property (p_dual) else $error("dual turn wrong");
  a_ctc: assert property (p_ctc) else $error("compare clear wrong");
  a_rd_b: assert property (p_rd_b) else $error("control B readback wrong");
  a_rd_a: assert property (p_rd_a) else $error("control A readback wrong");
endmodule
bind tmc_timer_ctrl tmc_timer_ctrl_assertions u_chk (
  .clock, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .count_out, .cmp_a_active, .count_down
);

// ---- verif/tb_timer16_mode_capture_clock_ctrl.sv ----
// Self-checking testbench for the timer control block
module tb_timer16_mode_capture_clock_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] DUAL = 16'h0F0E;
  localparam logic [15:0] OVF  = 16'hCFEF;
  logic        clock;
  logic        arst_n;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  wire  [7:0]  reg_rdata;
  wire         cap_pin;
  wire         ext_pin;
  wire  [15:0] count_out;
  wire  [15:0] cmp_a_active;
  wire         count_down;
  wire         irq;
  logic [7:0]  d;
  logic [15:0] v;
  int          n_errors = 0;
  int          cmp_count = 0;
  tmc_timer_ctrl u_dut (
    .clock(clock), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .capture_input_pin(cap_pin), .external_count_pin(ext_pin), .count_out(count_out),
    .cmp_a_active(cmp_a_active), .count_down(count_down), .irq(irq)
  );
  tmc_pin_model u_pin (
    .clock(clock), .capture_input_pin(cap_pin), .external_count_pin(ext_pin)
  );
  // ****************
  // Bus and compare
  // ****************
  task automatic finish_test;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
    cmp_count++;
    if ($isunknown(got) || got < lo || got > hi) begin
      n_errors++;
      $display("ERROR %0t got %h want %h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= x;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] x);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    x = reg_rdata;
  endtask
  task automatic wr16(input logic [7:0] a, input logic [15:0] x);
    wr(a, x[7:0]);
    wr(a + 8'h01, x[15:8]);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  function automatic logic [15:0] top_of(input logic [3:0] m);
    case (m)
      4'h1, 4'h5: top_of = 16'h00FF;
      4'h2, 4'h6: top_of = 16'h01FF;
      4'h3, 4'h7: top_of = 16'h03FF;
      4'h4, 4'h9, 4'hB, 4'hF: top_of = 16'h0040;
      default: top_of = 16'h0030;
    endcase
  endfunction
  // Edge on the pin, then expect a capture in a window after it, or none
  task automatic cap_try(input logic lvl, input logic hit, input int lo, input int hi);
    logic [15:0] c0;
    int          n;
    u_pin.cap_to(lvl);
    #1;
    c0 = count_out;
    n = 0;
    while (irq !== 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
    chk({15'h0, irq}, {15'h0, hit}, {15'h0, hit});
    if (hit && irq !== 1'b1) finish_test();
    if (hit) begin
      rd(8'h86, v[7:0]);
      rd(8'h87, v[15:8]);
      chk(v, c0 + 16'(lo), c0 + 16'(hi));
    end
    wr(8'h8C, 8'h02);
    cyc(2);
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_regs;
    rd(8'h81, d);
    chk(d, 16'h0, 16'h0);
    wr(8'h81, 8'hFF);
    rd(8'h81, d);
    chk(d, 16'hDF, 16'hDF);
    wr(8'h80, 8'hFF);
    rd(8'h80, d);
    chk(d, 16'h03, 16'h03);
    rd(8'h83, d);
    chk(d, 16'h0, 16'h0);
    wr(8'h81, 8'h00);
    wr(8'h80, 8'h00);
    wr16(8'h84, 16'h0010);
    cyc(20);
    chk(count_out, 16'h0010, 16'h0010);
  endtask
  task automatic t_presc;
    int dv[5] = '{1, 8, 64, 256, 1024};
    for (int i = 0; i < 5; i++) begin
      wr(8'h81, 8'h00);
      wr16(8'h84, 16'h0000);
      wr(8'h81, 8'(i + 1));
      cyc(4 * dv[i]);
      chk(count_out, 16'h0003, 16'h0005);
    end
  endtask
  task automatic t_modes;
    logic [15:0] mx;
    logic [15:0] tp;
    logic        dn;
    wr(8'h81, 8'h00);
    wr16(8'h88, 16'h0040);
    wr16(8'h86, 16'h0030);
    for (int m = 1; m < 16; m++) begin
      if (m == 13) continue;
      tp = top_of(4'(m));
      wr(8'h81, 8'h00);
      wr(8'h80, {6'h00, 2'(m)});
      wr16(8'h84, 16'h0000);
      wr(8'h8C, 8'h03);
      wr(8'h81, {3'h0, 2'(m >> 2), 3'h1});
      mx = 16'h0000;
      dn = 1'b0;
      repeat (2 * tp + 20) begin
        cyc(1);
        if (count_out > mx) mx = count_out;
        dn = dn | count_down;
      end
      chk(mx, tp, tp);
      chk({15'h0, dn}, {15'h0, DUAL[m]}, {15'h0, DUAL[m]});
      rd(8'h8C, d);
      chk({15'h0, d[0]}, {15'h0, OVF[m]}, {15'h0, OVF[m]});
    end
  endtask
  // Buffered compare holds until TOP in mode 1, then follows writes at once in mode 0
  task automatic t_buf;
    wr(8'h81, 8'h00);
    wr(8'h80, 8'h01);
    wr16(8'h84, 16'h00F0);
    wr16(8'h88, 16'h0033);
    cyc(3);
    chk(cmp_a_active, 16'h0040, 16'h0040);
    wr(8'h81, 8'h01);
    cyc(20);
    chk(cmp_a_active, 16'h0033, 16'h0033);
    wr(8'h81, 8'h00);
    wr(8'h80, 8'h00);
    wr16(8'h88, 16'h0044);
    cyc(2);
    chk(cmp_a_active, 16'h0044, 16'h0044);
  endtask
  task automatic t_irq;
    wr(8'h81, 8'h00);
    wr(8'h80, 8'h00);
    wr(8'h8D, 8'h00);
    wr(8'h8C, 8'h03);
    wr16(8'h84, 16'hFFF0);
    wr(8'h81, 8'h01);
    cyc(30);
    chk({15'h0, irq}, 16'h0, 16'h0);
    rd(8'h8C, d);
    chk({15'h0, d[0]}, 16'h1, 16'h1);
    wr(8'h8D, 8'h01);
    cyc(2);
    chk({15'h0, irq}, 16'h1, 16'h1);
    wr(8'h8C, 8'h01);
    cyc(2);
    chk({15'h0, irq}, 16'h0, 16'h0);
  endtask
  task automatic t_capture;
    wr(8'h8D, 8'h02);
    wr(8'h8C, 8'h03);
    wr(8'h81, 8'h41);
    cap_try(1'b0, 1'b0, 0, 0);
    cap_try(1'b1, 1'b1, 2, 6);
    wr(8'h81, 8'h01);
    cap_try(1'b0, 1'b1, 2, 6);
    cap_try(1'b1, 1'b0, 0, 0);
    wr(8'h81, 8'h81);
    u_pin.cap_glitch(2);
    cyc(12);
    chk({15'h0, irq}, 16'h0, 16'h0);
    cap_try(1'b0, 1'b1, 5, 10);
    wr(8'h80, 8'h02);
    wr(8'h81, 8'h59);
    cap_try(1'b1, 1'b0, 0, 0);
  endtask
  task automatic t_ext;
    wr(8'h81, 8'h00);
    wr(8'h80, 8'h00);
    wr16(8'h84, 16'h0000);
    wr(8'h81, 8'h07);
    u_pin.ext_pulse(5, 4);
    cyc(8);
    chk(count_out, 16'h0005, 16'h0005);
    wr(8'h81, 8'h00);
    wr16(8'h84, 16'h0000);
    wr(8'h81, 8'h06);
    u_pin.ext_pulse(3, 9);
    cyc(8);
    chk(count_out, 16'h0003, 16'h0003);
  endtask
  // ****************
  // Main
  // ****************
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    arst_n    = 1'b0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    t_regs();
    t_presc();
    t_modes();
    t_buf();
    t_irq();
    t_capture();
    t_ext();
    finish_test();
  end
endmodule
